// >>> logic/phase_timing_map.svh
`ifndef PHASE_TIMING_MAP_SVH
`define PHASE_TIMING_MAP_SVH

// System clock range limits in kHz
`define SYSCLK_MIN_KHZ      250
`define SYSCLK_MAX_KHZ      9000
`define CLK_RATE_KHZ        50000
// Divider bounds derived from the rate: longest half period rounds down,
// shortest rounds up
`define HALF_DIV_MAX        ((`CLK_RATE_KHZ) / (2 * `SYSCLK_MIN_KHZ))
`define HALF_DIV_MIN        (((`CLK_RATE_KHZ) + (2 * `SYSCLK_MAX_KHZ) - 1) / (2 * `SYSCLK_MAX_KHZ))
// Divider register width and reset value
`define DIV_W               8
`define DIV_RESET           8'h19
// Phase counting
`define PHASE_W             6
`define PHASE_MAX           6'h3f
// Token timeout in system clock periods
`define RING_TIMEOUT        6'h3f
// Voltage code fields
`define PAR_CODE_W          6
`define SER_WORD_W          8
`define SER_HINT_BIT        7
`define SER_CODE_W          7

`endif

// >>> logic/phase_timing_pkg.sv
package phase_timing_pkg;
  // Power-up ring probe states, Gray coded along the usual path
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_probe = 2'b01,
    st_run   = 2'b11,
    st_fault = 2'b10
  } probe_state_t;
endpackage : phase_timing_pkg

// >>> logic/multiphase_pwm_phase_timing.sv
`timescale 1ns/10ps
`include "phase_timing_map.svh"
module multiphase_pwm_phase_timing
  import phase_timing_pkg::*;
(
  // Clock and reset (enable acts as reset)
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Oscillator setting, stands in for the external resistor
  input  wire logic [`DIV_W-1:0]        osc_half_div,
  // Ring
  output logic                          system_clock_output,
  output logic                          token_output,
  input  wire logic                     token_input,
  // Mode strap and voltage codes
  input  wire logic                     mode_strap_bit,
  input  wire logic [`PAR_CODE_W-1:0]   parallel_code,
  input  wire logic [`SER_WORD_W-1:0]   serial_word,
  input  wire logic                     serial_word_valid,
  input  wire logic                     serial_target_core,
  input  wire logic                     serial_target_aux,
  // Outputs to planes and phase units
  output logic                          serial_voltage_mode,
  output logic                          parallel_voltage_mode,
  output logic [`SER_CODE_W-1:0]        core_setpoint,
  output logic [`SER_CODE_W-1:0]        aux_setpoint,
  output logic                          auxiliary_plane_hiz,
  output logic                          power_save_hint_n,
  // Ring status
  output logic [`PHASE_W-1:0]           phase_count,
  output logic                          ring_ok,
  output logic                          ring_fault
);

  // Registers
  probe_state_t            state_r, state_nxt;
  logic [`DIV_W-1:0]       div_cnt_r;
  logic                    sclk_r;
  logic                    tok_r;
  logic                    strap_taken_r;
  logic                    tin_s1_r, tin_s2_r, tin_prev_r;
  logic                    strap_s1_r, strap_s2_r;
  logic [`PHASE_W-1:0]     cnt_r;

  // Clamp a divider request into the legal oscillator range
  function automatic logic [`DIV_W-1:0] clamp_div(input logic [`DIV_W-1:0] d);
    if (d > `DIV_W'(`HALF_DIV_MAX))
      return `DIV_W'(`HALF_DIV_MAX);
    else if (d < `DIV_W'(`HALF_DIV_MIN))
      return `DIV_W'(`HALF_DIV_MIN);
    else
      return d;
  endfunction : clamp_div

  // Decode of divider, edges and ring events
  wire logic [`DIV_W-1:0] half_div  = clamp_div(osc_half_div);
  wire logic              half_tick = (div_cnt_r >= half_div - `DIV_W'(1));
  wire logic              fall_tick = half_tick & sclk_r;
  wire logic              tok_rise  = tin_s2_r & ~tin_prev_r;
  wire logic              timeout   = (cnt_r == `RING_TIMEOUT);

  // Oscillator divider: free-running system clock, clamped to the range
  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_r <= '0;
      sclk_r    <= 1'b0;
    end else if (half_tick) begin
      div_cnt_r <= '0;
      sclk_r    <= ~sclk_r;
    end else begin
      div_cnt_r <= div_cnt_r + `DIV_W'(1);
    end
  end

  // Two-flop synchroniser for the token pin; stage two and its delayed copy feed the edge detect
  always_ff @(posedge clk) begin
    if (rst) begin
      tin_s1_r   <= 1'b0;
      tin_s2_r   <= 1'b0;
      tin_prev_r <= 1'b0;
    end else begin
      tin_s1_r   <= token_input;
      tin_s2_r   <= tin_s1_r;
      tin_prev_r <= tin_s2_r;
    end
  end

  // Strap synchroniser runs through reset so stage two holds the pin at release
  always_ff @(posedge clk) begin
    strap_s1_r <= mode_strap_bit;
    strap_s2_r <= strap_s1_r;
  end

  // Probe sequencing: one token out, count clocks until it returns
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      st_idle:  if (fall_tick) state_nxt = st_probe;
      st_probe: begin
        if (tok_rise)
          state_nxt = st_run;
        else if (timeout)
          state_nxt = st_fault;
      end
      st_run:   state_nxt = st_run;
      st_fault: state_nxt = st_fault;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst)
      state_r <= st_idle;
    else
      state_r <= state_nxt;
  end

  // Token pulse and phase counter; each falling clock edge is one phase slot
  always_ff @(posedge clk) begin
    if (rst) begin
      tok_r       <= 1'b0;
      cnt_r       <= '0;
      phase_count <= '0;
    end else begin
      if (state_r == st_idle && fall_tick)
        tok_r <= 1'b1;
      else if (fall_tick)
        tok_r <= 1'b0;
      if (state_r == st_probe && fall_tick && !timeout)
        cnt_r <= cnt_r + `PHASE_W'(1);
      if (state_r == st_probe && tok_rise)
        phase_count <= cnt_r;
    end
  end

  // Outputs to ring; clock drives all phase units in parallel
  always_ff @(posedge clk) begin
    if (rst) begin
      system_clock_output <= 1'b0;
      token_output        <= 1'b0;
      ring_ok             <= 1'b0;
      ring_fault          <= 1'b0;
    end else begin
      system_clock_output <= sclk_r;
      token_output        <= tok_r;
      ring_ok             <= (state_nxt == st_run);
      ring_fault          <= (state_nxt == st_fault);
    end
  end

  // Strap capture on the first cycle after enable releases
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_taken_r         <= 1'b0;
      serial_voltage_mode   <= 1'b0;
      parallel_voltage_mode <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_taken_r         <= 1'b1;
      serial_voltage_mode   <= ~strap_s2_r;
      parallel_voltage_mode <= strap_s2_r;
    end
  end

  // Setpoints and power-save relay; words only act after mode is fixed
  wire logic       ser_go = strap_taken_r & serial_voltage_mode & serial_word_valid;
  wire logic [`SER_CODE_W-1:0] ser_code = serial_word[`SER_CODE_W-1:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      core_setpoint       <= '0;
      aux_setpoint        <= '0;
      auxiliary_plane_hiz <= 1'b1;
      power_save_hint_n   <= 1'b1;
    end else if (strap_taken_r && parallel_voltage_mode) begin
      core_setpoint       <= {1'b0, parallel_code};
      auxiliary_plane_hiz <= 1'b1;
      power_save_hint_n   <= 1'b1;
    end else if (strap_taken_r) begin
      auxiliary_plane_hiz <= 1'b0;
      if (ser_go && serial_target_core)
        core_setpoint <= ser_code;
      if (ser_go && serial_target_aux)
        aux_setpoint <= ser_code;
      if (ser_go)
        power_save_hint_n <= serial_word[`SER_HINT_BIT];
    end
  end

  // Checks
  sequence s_probe_start;
    state_r == st_idle && fall_tick;
  endsequence

  property p_token_issue;
    @(posedge clk) disable iff (rst)
      s_probe_start |-> ##2 token_output;
  endproperty
  a_token_issue: assert property (p_token_issue) else $error("token not issued");

  property p_fault_on_timeout;
    @(posedge clk) disable iff (rst)
      (state_r == st_probe && timeout && !tok_rise) |-> ##1 ring_fault;
  endproperty
  a_fault_on_timeout: assert property (p_fault_on_timeout) else $error("no fault");

  property p_count_latch;
    @(posedge clk) disable iff (rst)
      (state_r == st_probe && tok_rise) |=> (phase_count == $past(cnt_r)) && ring_ok;
  endproperty
  a_count_latch: assert property (p_count_latch) else $error("phase count wrong");

  property p_clock_follow;
    @(posedge clk) disable iff (rst)
      1'b1 |=> system_clock_output == $past(sclk_r);
  endproperty
  a_clock_follow: assert property (p_clock_follow) else $error("clock out lag");

  property p_modes_exclusive;
    @(posedge clk) disable iff (rst)
      strap_taken_r |-> (serial_voltage_mode != parallel_voltage_mode);
  endproperty
  a_modes_exclusive: assert property (p_modes_exclusive) else $error("mode clash");

  property p_mode_stable;
    @(posedge clk) disable iff (rst)
      $past(strap_taken_r) |-> $stable(serial_voltage_mode);
  endproperty
  a_mode_stable: assert property (p_mode_stable) else $error("mode changed");

  property p_aux_hiz;
    @(posedge clk) disable iff (rst)
      (strap_taken_r && parallel_voltage_mode) |=> auxiliary_plane_hiz;
  endproperty
  a_aux_hiz: assert property (p_aux_hiz) else $error("aux not high-Z");

  property p_hint;
    @(posedge clk) disable iff (rst)
      ser_go |=> power_save_hint_n == $past(serial_word[`SER_HINT_BIT]);
  endproperty
  a_hint: assert property (p_hint) else $error("hint mismatch");

  property p_core_serial;
    @(posedge clk) disable iff (rst)
      (ser_go && serial_target_core) |=> core_setpoint == $past(ser_code);
  endproperty
  a_core_serial: assert property (p_core_serial) else $error("core code lost");

  property p_half_range;
    @(posedge clk) disable iff (rst)
      half_div >= `DIV_W'(`HALF_DIV_MIN) && half_div <= `DIV_W'(`HALF_DIV_MAX);
  endproperty
  a_half_range: assert property (p_half_range) else $error("osc out of range");

endmodule : multiphase_pwm_phase_timing

// >>> tb/phase_ring_model.sv
`timescale 1ns/10ps
module phase_ring_model #(
  parameter int UNITS = 4
) (
  // Shared clock and ring ends
  input  wire logic sys_clk,
  input  wire logic ring_in,
  input  wire logic broken,
  output logic      ring_out
);
  logic [UNITS-1:0] stage_r;
  wire              ring_q;
  // Pre-edge copy of the token so a unit never races the controller's own update
  assign #1 ring_q = ring_in;
  initial stage_r = '0;
  // Each unit takes the shared clock and passes the token on its falling edge
  always @(negedge sys_clk) begin
    stage_r <= {stage_r[UNITS-2:0], ring_q};
  end
  // First unit's latch: error level and comparator ceiling in ramp steps
  localparam int ERR_LVL = 2;
  localparam int CMR_TOP = 8;
  localparam int REF_LVL = 1;
  int   ramp  = 0;
  logic pwm_q = 1'b0;
  logic hs_on = 1'b0;
  logic ls_on = 1'b1;
  // Reset only when ramp passes a level the comparator can see
  wire  rst_ev = (ERR_LVL <= CMR_TOP) && (ramp > ERR_LVL);
  // Reset checked first so it wins; set only at a clock fall
  always @(sys_clk) begin
    if (rst_ev)
      pwm_q <= 1'b0;
    else if (!sys_clk)
      pwm_q <= 1'b1;
    ramp <= pwm_q ? ramp + 1 : 0;
  end
  // Low side drops first, high side waits one blank step
  always @(sys_clk) begin
    ls_on <= !pwm_q && (ERR_LVL >= REF_LVL);
    hs_on <= pwm_q && !ls_on;
  end
  // A broken link leaves the return line at its idle low level
  assign ring_out = broken ? 1'b0 : stage_r[UNITS-1];
endmodule : phase_ring_model

// >>> tb/multiphase_pwm_phase_timing_tb_top.sv
`timescale 1ns/10ps
`include "phase_timing_map.svh"
module multiphase_pwm_phase_timing_tb_top;
  import phase_timing_pkg::*;
  logic clk, rst, strap, valid, tgt_core, tgt_aux, brk;
  logic [7:0] div, word;
  logic [5:0] pcode;
  wire sclk, tok_o, tok_i, smode, pmode, hiz, hint_n, r_ok, r_flt;
  wire [6:0] core_sp, aux_sp;
  wire [5:0] pcnt;
  int error_cnt = 0;
  int tests_run = 0;

  multiphase_pwm_phase_timing multiphase_pwm_phase_timing_i (
    .clk(clk), .rst(rst), .osc_half_div(div), .system_clock_output(sclk),
    .token_output(tok_o), .token_input(tok_i), .mode_strap_bit(strap),
    .parallel_code(pcode), .serial_word(word), .serial_word_valid(valid),
    .serial_target_core(tgt_core), .serial_target_aux(tgt_aux),
    .serial_voltage_mode(smode), .parallel_voltage_mode(pmode),
    .core_setpoint(core_sp), .aux_setpoint(aux_sp), .auxiliary_plane_hiz(hiz),
    .power_save_hint_n(hint_n), .phase_count(pcnt), .ring_ok(r_ok),
    .ring_fault(r_flt));
  phase_ring_model #(.UNITS(4)) phase_ring_model_i (
    .sys_clk(sclk), .ring_in(tok_o), .broken(brk), .ring_out(tok_i));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // Reset for 4 cycles with the strap set up, then let synchronisers settle
  task automatic start(input logic s, input logic b);
    @(posedge clk);
    strap <= s;
    brk   <= b;
    rst   <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("hiz in reset", 8'h01, {7'h00, hiz});
    chk("hint in reset", 8'h01, {7'h00, hint_n});
    chk("modes in reset", 8'h00, {6'h00, smode, pmode});
    rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : start

  // Bounded wait for the probe result
  task automatic wait_ring();
    int n;
    for (n = 0; n < 3000 && !(r_ok === 1'b1 || r_flt === 1'b1); n++) @(posedge clk);
    if (n == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
    #1;
  endtask : wait_ring

  task automatic send(input logic [7:0] w, input logic c, input logic a);
    @(posedge clk);
    word     <= w;
    tgt_core <= c;
    tgt_aux  <= a;
    valid    <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    #1;
  endtask : send

  // Serial mode: clock rate, ring of four, plane words and hint
  task automatic serial_case();
    int hi;
    start(1'b0, 1'b0);
    chk("serial mode", 8'h02, {6'h00, smode, pmode});
    chk("aux active", 8'h00, {7'h00, hiz});
    for (int n = 0; n < 200 && sclk !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    for (hi = 0; hi < 200 && sclk === 1'b1; hi++) begin
      @(posedge clk);
      #1;
    end
    chk("half period", div, hi[7:0]);
    wait_ring();
    chk("ring ok", 8'h01, {6'h00, r_flt, r_ok});
    chk("phase count", 8'h04, {2'b00, pcnt});
    send(8'h85, 1'b1, 1'b0);
    chk("core sp", 8'h05, {1'b0, core_sp});
    chk("hint high", 8'h01, {7'h00, hint_n});
    send(8'h22, 1'b0, 1'b1);
    chk("aux sp", 8'h22, {1'b0, aux_sp});
    chk("core kept", 8'h05, {1'b0, core_sp});
    chk("hint low", 8'h00, {7'h00, hint_n});
    send(8'hff, 1'b1, 1'b1);
    chk("both sp", 8'hff, {1'b0, core_sp, 1'b0} | {2'b00, aux_sp[6:1]});
  endtask : serial_case

  // Parallel mode with a broken ring: core from six bits, aux high-Z, fault flagged
  task automatic parallel_case();
    start(1'b1, 1'b1);
    chk("parallel mode", 8'h01, {6'h00, smode, pmode});
    chk("aux hiz", 8'h01, {7'h00, hiz});
    chk("core par", 8'h2a, {1'b0, core_sp});
    send(8'h03, 1'b1, 1'b1);
    chk("word ignored", 8'h2a, {1'b0, core_sp});
    wait_ring();
    chk("ring fault", 8'h02, {6'h00, r_flt, r_ok});
  endtask : parallel_case

  initial begin
    rst = 1'b1; strap = 1'b0; valid = 1'b0; tgt_core = 1'b0; tgt_aux = 1'b0;
    brk = 1'b0; div = 8'h0a; word = 8'h00; pcode = 6'h2a;
    serial_case();
    parallel_case();
    tally_and_finish();
  end
endmodule : multiphase_pwm_phase_timing_tb_top
